// *** include/sas_defines.svh ***
// Contract
// - each conversion resolves ten approximation bits, one per step, msb first
// - after the lsb, approximation bits go to that channel's result, or to results 0..3 in four-buffer select; reset value undefined
// - route one of eight channels per both mode registers; generate sample-and-hold timing
// - any write to either mode register aborts and restarts a running conversion
// - bit 6 of mode register a is read-only running flag; writes ignored
// - running flag rises three clocks after conversion start; software uses interrupt
// - software trigger mode: writing enable 1 starts a conversion
// - timer/external mode: enable 1 waits for trigger; only write 0 or reset clears
// - switching to timer/external with enable still 1 enters trigger wait at once
// - select mode: 3-bit field picks channel 0..7; timer trigger forbids 4..7; code limits external trigger to 0..3 as well
// - software scan converts 0..coded channel; timer scan counts triggers, match order
// - timer scan with top bit set: four triggers, then software scan upward
// - trigger field 6..4: 00x software, 010 timer one, 011 timer four, 110 external
// - clock field 2..0: 36, 48, 60, 72, 96, 120 system clocks per conversion
// - results read-only, 16 or 8 bit; 16-bit read has upper six bits zero
// - 8-bit read of upper result byte address returns high-byte view
// - done interrupt after one, after four, or after last scanned channel
// - four-buffer select converts one channel four times into results 0..3
// - timer/external: after sequence, return to trigger wait while enable stays 1
// - software mode stops after sequence; software writes enable 1 again to restart
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH

`define SAS_ADDR_MODE_A 32'hfffff380
`define SAS_ADDR_MODE_B 32'hfffff382
`define SAS_ADDR_RESULT0 32'hfffff310
`define SAS_MODE_A_RST 8'h00
`define SAS_MODE_B_RST 8'h07

`define SAS_BIT_CE 7
`define SAS_BIT_CS 6
`define SAS_BIT_BS 5
`define SAS_BIT_MS 4
`define SAS_TRG_LSB 4
`define SAS_FR_LSB 0

`define SAS_CS_DELAY 2'h3
`define SAS_STEPS_PER_CONV 12
`define SAS_SAMPLE_STEPS 4'h2
`define SAS_LAST_PHASE 4'hb
`define SAS_CLKS_FR0 36
`define SAS_CLKS_FR1 48
`define SAS_CLKS_FR2 60
`define SAS_CLKS_FR3 72
`define SAS_CLKS_FR4 96
`define SAS_CLKS_FR5 120
`define SAS_CLKS_FR6 144
`define SAS_CLKS_FR7 168

`endif

// *** include/sas_pkg.sv ***
package sas_pkg;

  typedef enum logic [2:0] {
    SAS_IDLE = 3'b001,
    SAS_WAIT = 3'b010,
    SAS_CONV = 3'b100
  } sas_state_t;

  typedef enum logic [2:0] {
    SAS_TRG_SW = 3'h0,
    SAS_TRG_TM1 = 3'h1,
    SAS_TRG_TM4 = 3'h2,
    SAS_TRG_EXT = 3'h3,
    SAS_TRG_BAD = 3'h4
  } sas_trig_t;

  typedef struct packed {
    sas_state_t st;
    logic ce;
    logic bs;
    logic ms;
    logic [2:0] anis;
    logic [2:0] trg;
    logic [2:0] fr;
    logic [7:0][9:0] res;
    logic [3:0] cnt;
    logic [2:0] ch;
    logic [2:0] dst;
    logic go;
    logic abort;
    logic cs;
    logic [1:0] cs_cnt;
    logic irq;
    logic [15:0] rdata;
    logic rvalid;
  } sas_regs_t;

  typedef struct packed {
    logic busy;
    logic [3:0] ph;
    logic [3:0] tick;
    logic [9:0] approx;
    logic sh;
    logic done;
  } sas_sar_t;

endpackage

// *** design/sas_sar_engine.sv ***
`timescale 1ns/100ps
`include "sas_defines.svh"

module sas_sar_engine import sas_pkg::*; (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic start,
  input wire logic abort,
  input wire logic [3:0] step_len,
  input wire logic comp_hi,
  output logic busy,
  output logic sample_hold,
  output logic [9:0] approx,
  output logic done
);

  sas_sar_t r_ff;
  sas_sar_t nxt_r;

  // phase 0..1 samples, phases 2..11 decide bits 9..0
  function automatic logic [3:0] bit_of(input logic [3:0] ph);
    bit_of = 4'(`SAS_LAST_PHASE - ph);
  endfunction

  // abort clears first so a restart in the same cycle still begins cleanly
  always_comb begin
    nxt_r = r_ff;
    nxt_r.done = 1'b0;
    if (abort) begin
      nxt_r = '0;
    end
    if (start) begin
      nxt_r.busy = 1'b1;
      nxt_r.ph = 4'h0;
      nxt_r.tick = 4'(step_len - 4'h1);
      nxt_r.approx = 10'h000;
      nxt_r.sh = 1'b1;
    end else if (r_ff.busy && !abort) begin // a bare abort must not finish the old conversion
      if (r_ff.tick != 4'h0) begin
        nxt_r.tick = 4'(r_ff.tick - 4'h1);
      end else begin
        nxt_r.tick = 4'(step_len - 4'h1);
        // trial bit stays only while the input is at or above the tap
        if (r_ff.ph >= `SAS_SAMPLE_STEPS) begin
          nxt_r.approx[bit_of(r_ff.ph)] = comp_hi;
        end
        if (r_ff.ph == `SAS_LAST_PHASE) begin
          nxt_r.busy = 1'b0;
          nxt_r.done = 1'b1;
        end else begin
          nxt_r.ph = 4'(r_ff.ph + 4'h1);
          if (4'(r_ff.ph + 4'h1) >= `SAS_SAMPLE_STEPS) begin
            nxt_r.approx[bit_of(4'(r_ff.ph + 4'h1))] = 1'b1;
          end
          nxt_r.sh = (4'(r_ff.ph + 4'h1) < `SAS_SAMPLE_STEPS);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign busy = r_ff.busy;
  assign sample_hold = r_ff.sh;
  assign approx = r_ff.approx;
  assign done = r_ff.done;

endmodule // sas_sar_engine

// *** design/sas_sequencer.sv ***
`timescale 1ns/100ps
`include "sas_defines.svh"

module sas_sequencer import sas_pkg::*; (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [31:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_byte,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic [3:0] tmr_match,
  input wire logic ext_trig,
  input wire logic comp_hi,
  output logic [2:0] chan_sel,
  output logic sample_hold,
  output logic [9:0] approx_bits,
  output logic conv_done_irq,
  output logic conv_running
);

  sas_regs_t r_ff;
  sas_regs_t nxt_r;
  logic sar_done;
  logic [9:0] sar_bits;
  logic sar_sh;
  logic wr_a;
  logic wr_b;
  logic wr_hit;
  sas_trig_t mode;
  sas_trig_t new_mode;
  logic new_ce;
  logic [7:0] new_a;
  logic [7:0] new_b;

  // trigger field decode; unlisted codes never start anything
  function automatic sas_trig_t trig_mode(input logic [2:0] trg);
    case (trg)
      3'h0, 3'h1: trig_mode = SAS_TRG_SW;
      3'h2: trig_mode = SAS_TRG_TM1;
      3'h3: trig_mode = SAS_TRG_TM4;
      3'h6: trig_mode = SAS_TRG_EXT;
      default: trig_mode = SAS_TRG_BAD;
    endcase
  endfunction

  // step length is a twelfth of the conversion clock count
  function automatic logic [3:0] step_len(input logic [2:0] fr);
    case (fr)
      3'h0: step_len = 4'(`SAS_CLKS_FR0 / `SAS_STEPS_PER_CONV);
      3'h1: step_len = 4'(`SAS_CLKS_FR1 / `SAS_STEPS_PER_CONV);
      3'h2: step_len = 4'(`SAS_CLKS_FR2 / `SAS_STEPS_PER_CONV);
      3'h3: step_len = 4'(`SAS_CLKS_FR3 / `SAS_STEPS_PER_CONV);
      3'h4: step_len = 4'(`SAS_CLKS_FR4 / `SAS_STEPS_PER_CONV);
      3'h5: step_len = 4'(`SAS_CLKS_FR5 / `SAS_STEPS_PER_CONV);
      3'h6: step_len = 4'(`SAS_CLKS_FR6 / `SAS_STEPS_PER_CONV);
      default: step_len = 4'(`SAS_CLKS_FR7 / `SAS_STEPS_PER_CONV);
    endcase
  endfunction

  // conversions per sequence: 1, 4, or channels 0..field in scan
  function automatic logic [3:0] seq_total(input logic ms, input logic bs, input logic [2:0] anis);
    if (ms) begin
      seq_total = bs ? 4'h4 : 4'h1;
    end else begin
      seq_total = 4'({1'b0, anis} + 4'h1);
    end
  endfunction

  // lowest firing compare match names the channel in timer scan
  function automatic logic [2:0] match_chan(input logic [3:0] m);
    if (m[0]) begin
      match_chan = 3'h0;
    end else if (m[1]) begin
      match_chan = 3'h1;
    end else if (m[2]) begin
      match_chan = 3'h2;
    end else begin
      match_chan = 3'h3;
    end
  endfunction

  // channel for conversion number cnt; triggered select mode only reaches 0..3
  function automatic logic [2:0] pick_chan(input sas_trig_t md, input logic ms, input logic [2:0] anis,
                                           input logic [3:0] cnt, input logic [3:0] m);
    logic timed;
    timed = (md == SAS_TRG_TM1) || (md == SAS_TRG_TM4);
    if (ms) begin
      pick_chan = (md == SAS_TRG_SW) ? anis : {1'b0, anis[1:0]};
    end else if (timed && cnt < 4'h4) begin
      pick_chan = match_chan(m);
    end else begin
      pick_chan = cnt[2:0];
    end
  endfunction

  // four-buffer select fills results 0..3, otherwise result follows channel
  function automatic logic [2:0] pick_dst(input logic ms, input logic bs, input logic [3:0] cnt,
                                          input logic [2:0] ch);
    pick_dst = (ms && bs) ? cnt[2:0] : ch;
  endfunction

  // does each of the first four conversions of the sequence wait for its own trigger
  function automatic logic per_trig(input sas_trig_t md, input logic ms, input logic bs);
    per_trig = (md == SAS_TRG_TM4 && ms && bs) ||
               ((md == SAS_TRG_TM1 || md == SAS_TRG_TM4) && !ms);
  endfunction

  // read view: mode regs in low byte, results zero-extended or high-byte view
  function automatic logic [15:0] read_mux(input sas_regs_t r, input logic [31:0] a, input logic byt);
    logic [9:0] res;
    read_mux = 16'h0000;
    res = r.res[a[3:1]];
    if (a == `SAS_ADDR_MODE_A) begin
      read_mux = {8'h00, r.ce, r.cs, r.bs, r.ms, 1'b0, r.anis};
    end else if (a == `SAS_ADDR_MODE_B) begin
      read_mux = {8'h00, 1'b0, r.trg, 1'b0, r.fr};
    end else if (a[31:4] == 28'(`SAS_ADDR_RESULT0 >> 4)) begin
      if (byt && a[0]) begin
        read_mux = {8'h00, res[9:2]};
      end else if (byt) begin
        read_mux = {8'h00, res[7:0]};
      end else begin
        read_mux = {6'h00, res};
      end
    end
  endfunction

  // write decode; the running flag position of the written data is dropped
  always_comb begin
    wr_a = bus_wr && (bus_addr == `SAS_ADDR_MODE_A);
    wr_b = bus_wr && (bus_addr == `SAS_ADDR_MODE_B);
    wr_hit = wr_a || wr_b;
    new_a = wr_a ? bus_wdata[7:0] : {r_ff.ce, 1'b0, r_ff.bs, r_ff.ms, 1'b0, r_ff.anis};
    new_b = wr_b ? bus_wdata[7:0] : {1'b0, r_ff.trg, 1'b0, r_ff.fr};
    new_ce = new_a[`SAS_BIT_CE];
    new_mode = trig_mode(new_b[`SAS_TRG_LSB +: 3]);
    mode = trig_mode(r_ff.trg);
  end

  // sequencing, trigger wait and register writes; writes come last so they win
  always_comb begin
    nxt_r = r_ff;
    nxt_r.go = 1'b0;
    nxt_r.abort = 1'b0;
    nxt_r.irq = 1'b0;
    nxt_r.rvalid = 1'b0;
    if (r_ff.cs_cnt != 2'h0) begin
      nxt_r.cs_cnt = 2'(r_ff.cs_cnt - 2'h1);
      if (r_ff.cs_cnt == 2'h1) begin
        nxt_r.cs = 1'b1;
      end
    end
    // a finished conversion is stored unless a mode write lands in the same cycle
    if (r_ff.st == SAS_CONV && sar_done && !wr_hit) begin
      nxt_r.res[r_ff.dst] = sar_bits;
      if (4'(r_ff.cnt + 4'h1) == seq_total(r_ff.ms, r_ff.bs, r_ff.anis)) begin
        nxt_r.irq = 1'b1;
        nxt_r.cnt = 4'h0;
        nxt_r.cs = 1'b0;
        nxt_r.cs_cnt = 2'h0;
        nxt_r.st = (mode == SAS_TRG_SW) ? SAS_IDLE : SAS_WAIT;
      end else begin
        nxt_r.cnt = 4'(r_ff.cnt + 4'h1);
        if (per_trig(mode, r_ff.ms, r_ff.bs) && 4'(r_ff.cnt + 4'h1) < 4'h4) begin
          nxt_r.st = SAS_WAIT;
        end else begin
          nxt_r.go = 1'b1;
          nxt_r.ch = pick_chan(mode, r_ff.ms, r_ff.anis, nxt_r.cnt, tmr_match);
          nxt_r.dst = pick_dst(r_ff.ms, r_ff.bs, nxt_r.cnt, nxt_r.ch);
        end
      end
    end
    // trigger wait: timer matches or the external trigger kick off a conversion
    if (r_ff.st == SAS_WAIT &&
        (((mode == SAS_TRG_TM1 || mode == SAS_TRG_TM4) && tmr_match != 4'h0) ||
         (mode == SAS_TRG_EXT && ext_trig))) begin
      nxt_r.st = SAS_CONV;
      nxt_r.go = 1'b1;
      nxt_r.ch = pick_chan(mode, r_ff.ms, r_ff.anis, r_ff.cnt, tmr_match);
      nxt_r.dst = pick_dst(r_ff.ms, r_ff.bs, r_ff.cnt, nxt_r.ch);
      if (r_ff.cnt == 4'h0) begin
        nxt_r.cs_cnt = `SAS_CS_DELAY;
      end
    end
    // any mode write restarts from scratch, even when nothing changed
    if (wr_hit) begin
      nxt_r.ce = new_ce;
      nxt_r.bs = new_a[`SAS_BIT_BS];
      nxt_r.ms = new_a[`SAS_BIT_MS];
      nxt_r.anis = new_a[2:0];
      nxt_r.trg = new_b[`SAS_TRG_LSB +: 3];
      nxt_r.fr = new_b[`SAS_FR_LSB +: 3];
      nxt_r.abort = 1'b1;
      nxt_r.cnt = 4'h0;
      nxt_r.cs = 1'b0;
      nxt_r.cs_cnt = 2'h0;
      if (!new_ce || new_mode == SAS_TRG_BAD) begin
        nxt_r.st = SAS_IDLE;
      end else if (new_mode == SAS_TRG_SW) begin
        nxt_r.st = SAS_CONV;
        nxt_r.go = 1'b1;
        nxt_r.ch = pick_chan(new_mode, nxt_r.ms, nxt_r.anis, 4'h0, tmr_match);
        nxt_r.dst = pick_dst(nxt_r.ms, nxt_r.bs, 4'h0, nxt_r.ch);
        nxt_r.cs_cnt = `SAS_CS_DELAY;
      end else begin
        nxt_r.st = SAS_WAIT;
      end
    end
    if (bus_rd) begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rdata = read_mux(r_ff, bus_addr, bus_byte);
    end
  end

  // results clear to zero here although software must treat them as unknown
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r_ff <= '0;
      r_ff.st <= SAS_IDLE;
      r_ff.fr <= 3'(`SAS_MODE_B_RST);
      r_ff.trg <= 3'(`SAS_MODE_B_RST >> `SAS_TRG_LSB);
    end else begin
      r_ff <= nxt_r;
    end
  end

  sas_sar_engine u_sar (
    .mclk(mclk),
    .nrst(nrst),
    .start(r_ff.go),
    .abort(r_ff.abort),
    .step_len(step_len(r_ff.fr)),
    .comp_hi(comp_hi),
    .busy(),
    .sample_hold(sar_sh),
    .approx(sar_bits),
    .done(sar_done)
  );

  assign bus_rdata = r_ff.rdata;
  assign bus_rvalid = r_ff.rvalid;
  assign chan_sel = r_ff.ch;
  assign sample_hold = sar_sh;
  assign approx_bits = sar_bits;
  assign conv_done_irq = r_ff.irq;
  assign conv_running = r_ff.cs;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // the flag counter needs three quiet edges after the start before the flag shows
  a_cs_delay_three: assert property ((r_ff.go && r_ff.cs_cnt == 2'h3 && !wr_hit) ##1 !wr_hit ##1 !wr_hit
    |=> r_ff.cs)
    else $error("running flag not set three clocks after start");
  a_cs_not_early: assert property ((r_ff.go && r_ff.cs_cnt == 2'h3) |-> !r_ff.cs ##1 !r_ff.cs)
    else $error("running flag rose too early");
  a_cs_write_ignored: assert property (wr_a |=> !r_ff.cs)
    else $error("write set the running flag");
  a_write_aborts: assert property (wr_hit |=> r_ff.abort && r_ff.cnt == 4'h0)
    else $error("mode write did not restart the sequence");
  a_sw_start_conv: assert property (wr_hit && new_ce && new_mode == SAS_TRG_SW
    |=> r_ff.st == SAS_CONV && r_ff.go)
    else $error("software start did not begin a conversion");
  a_trig_wait_enter: assert property (wr_hit && new_ce
    && new_mode inside {SAS_TRG_TM1, SAS_TRG_TM4, SAS_TRG_EXT} |=> r_ff.st == SAS_WAIT)
    else $error("trigger mode did not enter trigger wait");
  a_result_store: assert property (r_ff.st == SAS_CONV && sar_done && !wr_hit
    |=> r_ff.res[$past(r_ff.dst)] == $past(sar_bits))
    else $error("finished bits not stored");
  a_irq_after_done: assert property (r_ff.irq |-> $past(sar_done) && !$past(wr_hit))
    else $error("interrupt without a finished conversion");
  a_sw_seq_stops: assert property (r_ff.irq && mode == SAS_TRG_SW |-> r_ff.st == SAS_IDLE)
    else $error("software sequence did not stop");
  a_trig_rewait: assert property (r_ff.irq && mode != SAS_TRG_SW |-> r_ff.st == SAS_WAIT && r_ff.ce)
    else $error("triggered sequence did not return to wait");
  a_rd_upper_zero: assert property (bus_rd && !bus_byte |=> bus_rvalid && bus_rdata[15:10] == 6'h00)
    else $error("upper result bits not zero");
  // done at code 0 trails its start pulse by one engine edge plus 36 clocks; aborts leave no done
  a_conv_length: assert property (sar_done && r_ff.fr == 3'h0 |-> $past(r_ff.go, 37))
    else $error("conversion length wrong for code 0");

  c_sw_single: cover property (r_ff.irq && mode == SAS_TRG_SW && r_ff.ms && !r_ff.bs);
  c_four_buffer: cover property (r_ff.irq && r_ff.ms && r_ff.bs);
  c_timer_scan: cover property (r_ff.irq && mode == SAS_TRG_TM1 && !r_ff.ms && r_ff.anis[2]);
  c_abort_running: cover property (wr_hit && r_ff.st == SAS_CONV);

endmodule // sas_sequencer

// *** verif/sas_analog_model.sv ***
`timescale 1ns/100ps

module sas_analog_model (
  input wire logic [2:0] chan_sel,
  input wire logic [9:0] approx_bits,
  output logic comp_hi
);
  logic [9:0] vin;

  // every channel carries its own fixed level, so a wrong route gives a wrong result
  assign vin = 10'h0a5 + 10'h071 * {7'h00, chan_sel};
  // trial bit is kept while the input is at or above the tap; no settling delay is modelled
  assign comp_hi = (vin >= approx_bits);
endmodule // sas_analog_model

// *** verif/sar_adc_sequencer_tb.sv ***
`timescale 1ns/100ps
`include "sas_defines.svh"

module sar_adc_sequencer_tb;
  logic mclk, nrst, bus_wr, bus_rd, bus_byte, ext_trig, comp_hi, bus_rvalid;
  logic sample_hold, conv_done_irq, conv_running;
  logic [31:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata, rv;
  logic [3:0] tmr_match;
  logic [2:0] chan_sel;
  logic [9:0] approx_bits;
  int mismatches, checked, n;
  int clks [8] = '{36, 48, 60, 72, 96, 120, 144, 168};
  localparam logic [31:0] MA = `SAS_ADDR_MODE_A;
  localparam logic [31:0] MB = `SAS_ADDR_MODE_B;
  localparam logic [31:0] R0 = `SAS_ADDR_RESULT0;

  sas_sequencer dut_u (.mclk(mclk), .nrst(nrst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_byte(bus_byte), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .tmr_match(tmr_match), .ext_trig(ext_trig), .comp_hi(comp_hi), .chan_sel(chan_sel),
    .sample_hold(sample_hold), .approx_bits(approx_bits), .conv_done_irq(conv_done_irq),
    .conv_running(conv_running));
  sas_analog_model model_u (.chan_sel(chan_sel), .approx_bits(approx_bits), .comp_hi(comp_hi));

  // free-running system clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [9:0] lvl(input int c);
    return 10'h0a5 + 10'h071 * c[9:0];
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // mode registers are 8 bits wide, so writes go as byte accesses
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= {8'h00, d};
    bus_byte <= 1'b1;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic b, input logic [15:0] exp, input string what);
    @(posedge mclk);
    bus_addr <= a;
    bus_byte <= b;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    chk("rvalid", 16'h0001, {15'h0000, bus_rvalid});
    chk(what, exp, bus_rdata);
  endtask

  // n counts edges from the caller's last edge up to the done pulse
  task automatic wait_irq();
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (conv_done_irq !== 1'b1 && n < 800);
    chk("done_irq", 16'h0001, {15'h0000, conv_done_irq});
  endtask
  task automatic no_irq(input int k, input logic run);
    repeat (k) begin
      @(posedge mclk);
      #1;
      if (conv_done_irq !== 1'b0 || conv_running !== run) chk("idle", 16'h0000, 16'h0001);
    end
  endtask

  task automatic t_reset();
    rd(MA, 1'b1, 16'h0000, "mode_a_rst");
    rd(MB, 1'b1, 16'h0007, "mode_b_rst");
    rd(32'hfffff3f0, 1'b0, 16'h0000, "unmapped");
    wr(MA, 8'h43);
    rd(MA, 1'b1, 16'h0003, "mode_a_ro_bit");
  endtask

  // conversion length per clock code; n starts two edges into the conversion, ends one after done
  task automatic t_rate();
    for (int f = 0; f < 8; f++) begin
      wr(MB, f[7:0]);
      wr(MA, 8'h90);
      repeat (2) @(posedge mclk);
      #1;
      chk("running_early", 16'h0000, {15'h0000, conv_running});
      chk("sample_hold", 16'h0001, {15'h0000, sample_hold});
      @(posedge mclk);
      #1;
      chk("running_on", 16'h0001, {15'h0000, conv_running});
      wait_irq();
      chk("latency", 16'(clks[f] - 1), 16'(n));
      chk("running_off", 16'h0000, {15'h0000, conv_running});
    end
    rd(R0, 1'b0, {6'h00, lvl(0)}, "res0");
  endtask

  task automatic t_sel1();
    wr(MB, 8'h10);
    wr(MA, 8'h97);
    wait_irq();
    rd(R0 + 14, 1'b0, {6'h00, lvl(7)}, "res7_16");
    rd(R0 + 15, 1'b1, 16'(lvl(7) >> 2), "res7_hi");
    rd(R0 + 14, 1'b1, 16'(lvl(7) & 10'h0ff), "res7_lo");
    wr(R0 + 14, 8'h00);
    rd(R0 + 14, 1'b0, {6'h00, lvl(7)}, "res7_ro");
    no_irq(60, 1'b0);
    rd(MA, 1'b1, 16'h0097, "ce_kept");
  endtask

  task automatic t_abort();
    wr(MB, 8'h00);
    wr(MA, 8'h93);
    repeat (20) @(posedge mclk);
    rd(MA, 1'b1, 16'h00d3, "running_bit");
    wr(MB, 8'h00);
    wait_irq();
    chk("restart", 16'(38), 16'(n));
  endtask

  task automatic t_seq(input logic [7:0] mode, input int c0, input int c1, input int c2, input int c3);
    wr(MA, mode);
    wait_irq();
    chk("late_irq", 16'h0001, {15'h0000, n > 117});
    rd(R0, 1'b0, {6'h00, lvl(c0)}, "slot0");
    rd(R0 + 2, 1'b0, {6'h00, lvl(c1)}, "slot1");
    rd(R0 + 4, 1'b0, {6'h00, lvl(c2)}, "slot2");
    rd(R0 + 6, 1'b0, {6'h00, lvl(c3)}, "slot3");
  endtask

  task automatic pulse(input logic [3:0] m, input logic e);
    @(posedge mclk);
    tmr_match <= m;
    ext_trig <= e;
    @(posedge mclk);
    tmr_match <= 4'h0;
    ext_trig <= 1'b0;
  endtask

  task automatic t_trig();
    wr(MB, 8'h20);
    wr(MA, 8'h91);
    no_irq(60, 1'b0);
    pulse(4'h2, 1'b0);
    wait_irq();
    rd(R0 + 2, 1'b0, {6'h00, lvl(1)}, "tm_res1");
    no_irq(40, 1'b0);
    pulse(4'h2, 1'b0);
    wait_irq();
    wr(MB, 8'h30);
    wr(MA, 8'h81);
    pulse(4'h1, 1'b0);
    repeat (3) @(posedge mclk);
    no_irq(60, 1'b1);
    pulse(4'h2, 1'b0);
    wait_irq();
    rd(R0, 1'b0, {6'h00, lvl(0)}, "tm4_res0");
    rd(R0 + 2, 1'b0, {6'h00, lvl(1)}, "tm4_res1");
    wr(MB, 8'h00);
    wr(MA, 8'h96);
    wait_irq();
    wr(MB, 8'h60);
    no_irq(60, 1'b0);
    pulse(4'h0, 1'b1);
    wait_irq();
    wr(MB, 8'h70);
    wr(MA, 8'h90);
    pulse(4'h1, 1'b1);
    no_irq(100, 1'b0);
  endtask

  task automatic final_report();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog sized well beyond the roughly two thousand cycles the run needs
  initial begin
    #(50 * 40000);
    mismatches++;
    final_report();
  end

  initial begin
    nrst = 1'b0;
    bus_addr = 32'h00000000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_byte = 1'b0;
    bus_wdata = 16'h0000;
    tmr_match = 4'h0;
    ext_trig = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_rate();
    t_sel1();
    t_abort();
    wr(MB, 8'h00);
    t_seq(8'h83, 0, 1, 2, 3);
    t_seq(8'hb2, 2, 2, 2, 2);
    t_trig();
    final_report();
  end
endmodule // sar_adc_sequencer_tb
